// [hdl/mfrc_defines.svh]
`ifndef MFRC_DEFINES_SVH
`define MFRC_DEFINES_SVH

// register offsets (byte addresses)
`define MFRC_ADDR_W 12
`define MFRC_OFF_CONTROL 12'h100
`define MFRC_OFF_ADDR_HI 12'h104
`define MFRC_OFF_ADDR_LO 12'h108
`define MFRC_OFF_HASH_HI 12'h10C
`define MFRC_OFF_HASH_LO 12'h110
`define MFRC_OFF_WAKEUP 12'h12C
`define MFRC_OFF_TX_STATUS 12'h200

// control and wakeup register field positions
`define MFRC_BIT_HASH_ONLY 15
`define MFRC_BIT_HASH_FILT 13
`define MFRC_BIT_LATE_RETRY 12
`define MFRC_BIT_BROADCAST_REJECT_REJ 11
`define MFRC_BIT_NO_RETRY 10
`define MFRC_BIT_PAD_STRIP 8
`define MFRC_BACKOFF_LIMIT_HI 7
`define MFRC_BACKOFF_LIMIT_LO 6
`define MFRC_BIT_WAKEUP_EN 2

// reset values
`define MFRC_CONTROL_RESET 32'h0000_0000
`define MFRC_STATION_RESET 48'h0000_0000_0000
`define MFRC_HASH_RESET 64'h0000_0000_0000_0000
`define MFRC_LFSR_SEED 20'h00001

// frame and retry figures
`define MFRC_MIN_LEN_FIELD 16'h002E
`define MFRC_MAX_ATTEMPTS 5'h10
`define MFRC_K_MAX 4'hA
`define MFRC_CAP_00 4'hA
`define MFRC_CAP_01 4'h8
`define MFRC_CAP_10 4'h4
`define MFRC_CAP_11 4'h1
`define MFRC_CRC_POLY 32'h04C1_1DB7
`define MFRC_CRC_INIT 32'hFFFF_FFFF

// timing
`define MFRC_CLK_PERIOD_NS 100
`define MFRC_BIT_TIME_NS 100
`define MFRC_SLOT_BITS 512
`define MFRC_SLOT_CYCLES ((`MFRC_SLOT_BITS * `MFRC_BIT_TIME_NS) / `MFRC_CLK_PERIOD_NS)

`endif

// [hdl/mfrc_pkg.sv]
package mfrc_pkg;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_ACTIVE,
    TX_BACKOFF
  } mfrc_tx_state_t;

  typedef struct packed {
    logic [19:0] q;
  } mfrc_lfsr_state_t;

  typedef struct packed {
    logic [15:0] slot_cnt;
    logic [9:0] count;
    logic busy;
    logic done;
  } mfrc_backoff_state_t;

  typedef struct packed {
    logic hash_only;
    logic hash_filt;
    logic late_retry;
    logic broadcast_reject_rej;
    logic no_retry;
    logic pad_strip;
    logic [1:0] bo_limit;
    logic wake_en;
    logic [47:0] station;
    logic [63:0] hash_tbl;
    logic [31:0] rdata;
    mfrc_tx_state_t tx_state;
    logic [4:0] retries;
    logic frame_late;
    logic rx_valid;
    logic rx_accept;
    logic rx_strip;
    logic rx_wake;
    logic tx_retry;
    logic tx_abandon;
    logic stat_valid;
    logic stat_late;
    logic stat_err;
    logic bo_busy;
  } mfrc_state_t;

endpackage : mfrc_pkg

// [hdl/mfrc_lfsr.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mfrc_defines.svh"

module mfrc_lfsr (
  input wire logic core_clk, // block clock
  input wire logic reset_n, // async reset, active low
  output logic [19:0] lfsr_q // current register value
);
  import mfrc_pkg::*;

  mfrc_lfsr_state_t st_reg;
  mfrc_lfsr_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // free-running shift, taps 20 and 17
  always_comb begin
    st_next = st_reg;
    st_next.q = {st_reg.q[18:0], st_reg.q[19] ^ st_reg.q[16]};
  end

  // register the state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.q <= `MFRC_LFSR_SEED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lfsr_q = st_reg.q;

endmodule : mfrc_lfsr
`default_nettype wire

// [hdl/mfrc_backoff.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mfrc_defines.svh"

module mfrc_backoff #(
  parameter logic [15:0] SLOT_CYCLES = 16'(`MFRC_SLOT_CYCLES)
) (
  input wire logic core_clk, // block clock
  input wire logic reset_n, // async reset, active low
  input wire logic load, // start a countdown
  input wire logic [9:0] load_value, // slot times to wait
  output logic busy, // countdown running
  output logic done // one-cycle pulse at the end
);
  import mfrc_pkg::*;

  mfrc_backoff_state_t st_reg;
  mfrc_backoff_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // slot divider and countdown to zero
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (load) begin
      st_next.count = load_value;
      st_next.slot_cnt = 16'h0000;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.count == 10'h000) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else if (st_reg.slot_cnt == SLOT_CYCLES - 16'h0001) begin
        st_next.slot_cnt = 16'h0000;
        st_next.count = st_reg.count - 10'h001;
      end else begin
        st_next.slot_cnt = st_reg.slot_cnt + 16'h0001;
      end
    end
  end

  // register the state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;

endmodule : mfrc_backoff
`default_nettype wire

// [hdl/mfrc_top.sv]
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "mfrc_defines.svh"

module mfrc_top #(
  parameter logic [15:0] SLOT_CYCLES = 16'(`MFRC_SLOT_CYCLES)
) (
  input wire logic core_clk, // block clock, 10 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic [`MFRC_ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic rx_dest_valid, // destination and length present
  input wire logic [47:0] rx_dest_addr, // destination, first octet in [7:0]
  input wire logic [15:0] rx_len_field, // received length field
  input wire logic rx_wakeup_match, // frame matches a wakeup filter
  output logic rx_filter_valid, // filter decision pulse
  output logic rx_accept, // frame passes to the application
  output logic rx_strip_pad_fcs, // remove pad and FCS
  output logic rx_wakeup_hit, // broadcast wakeup frame seen
  input wire logic tx_start, // first attempt of a new frame
  input wire logic tx_collision, // collision on current attempt
  input wire logic tx_collision_late, // collision was a late one
  input wire logic tx_done, // current frame sent
  output logic tx_retry, // start the next attempt
  output logic tx_abandon, // drop frame, go to next
  output logic tx_status_valid, // per-frame status pulse
  output logic tx_status_late, // late collision seen on frame
  output logic tx_status_retry_err, // retry error on frame
  output logic tx_backoff_busy // waiting out a backoff
);
  import mfrc_pkg::*;

  mfrc_state_t st_reg;
  mfrc_state_t st_next;
  logic [19:0] lfsr_q;
  logic bo_load;
  logic [9:0] bo_value;
  logic bo_busy;
  logic bo_done;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // smaller of two bit counts
  function automatic logic [3:0] mfrc_min4(input logic [3:0] a, input logic [3:0] b);
    mfrc_min4 = (a < b) ? a : b;
  endfunction : mfrc_min4

  // bit cap selected by the backoff-limit field
  function automatic logic [3:0] mfrc_cap(input logic [1:0] lim);
    case (lim)
      2'h0: mfrc_cap = `MFRC_CAP_00;
      2'h1: mfrc_cap = `MFRC_CAP_01;
      2'h2: mfrc_cap = `MFRC_CAP_10;
      default: mfrc_cap = `MFRC_CAP_11;
    endcase
  endfunction : mfrc_cap

  // mask of the low n bits
  // n may reach ten, so the shift runs one bit wider than the mask
  function automatic logic [9:0] mfrc_low_mask(input logic [3:0] n);
    logic [10:0] one_up;
    one_up = 11'h001 << n;
    mfrc_low_mask = 10'(one_up - 11'h001);
  endfunction : mfrc_low_mask

  // six-bit hash index from the frame crc of the destination
  // no final inversion: the index is the top six bits of the running crc
  function automatic logic [5:0] mfrc_hash6(input logic [47:0] d);
    logic [31:0] crc;
    logic fb;
    crc = `MFRC_CRC_INIT;
    fb = 1'b0;
    for (int i = 0; i < 48; i++) begin
      fb = crc[31] ^ d[i];
      crc = {crc[30:0], 1'b0};
      if (fb) begin
        crc = crc ^ `MFRC_CRC_POLY;
      end
    end
    mfrc_hash6 = crc[31:26];
  endfunction : mfrc_hash6

  ////////////////////////////////////////////////////////////////////////////
  // random source and slot-time countdown

  mfrc_lfsr u_lfsr (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .lfsr_q(lfsr_q)
  );

  mfrc_backoff #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_backoff (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(bo_load),
    .load_value(bo_value),
    .busy(bo_busy),
    .done(bo_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: registers, receive filter, transmit retry
  always_comb begin
    logic is_broadcast_reject;
    logic is_mcast;
    logic exact_hit;
    logic hash_hit;
    logic late_now;
    logic [4:0] tries;
    logic [3:0] k_val;
    logic [3:0] used;
    is_broadcast_reject = &rx_dest_addr;
    is_mcast = rx_dest_addr[0];
    exact_hit = (rx_dest_addr == st_reg.station);
    hash_hit = st_reg.hash_tbl[mfrc_hash6(rx_dest_addr)];
    late_now = st_reg.frame_late | tx_collision_late;
    tries = st_reg.retries + 5'h01;
    k_val = (tries > 5'(`MFRC_K_MAX)) ? `MFRC_K_MAX : tries[3:0];
    used = mfrc_min4(k_val, mfrc_cap(st_reg.bo_limit));
    // a zero draw still runs the countdown, so every retry takes the same path
    bo_value = lfsr_q[9:0] & mfrc_low_mask(used);
    bo_load = 1'b0;

    st_next = st_reg;
    st_next.rdata = 32'h0000_0000;
    st_next.rx_valid = 1'b0;
    st_next.tx_retry = 1'b0;
    st_next.tx_abandon = 1'b0;
    st_next.stat_valid = 1'b0;
    st_next.bo_busy = bo_busy;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `MFRC_OFF_CONTROL: begin
          st_next.hash_only = reg_wdata[`MFRC_BIT_HASH_ONLY];
          st_next.hash_filt = reg_wdata[`MFRC_BIT_HASH_FILT];
          st_next.late_retry = reg_wdata[`MFRC_BIT_LATE_RETRY];
          st_next.broadcast_reject_rej = reg_wdata[`MFRC_BIT_BROADCAST_REJECT_REJ];
          st_next.no_retry = reg_wdata[`MFRC_BIT_NO_RETRY];
          st_next.pad_strip = reg_wdata[`MFRC_BIT_PAD_STRIP];
          st_next.bo_limit = reg_wdata[`MFRC_BACKOFF_LIMIT_HI:`MFRC_BACKOFF_LIMIT_LO];
        end
        `MFRC_OFF_ADDR_HI: st_next.station[47:32] = reg_wdata[15:0];
        `MFRC_OFF_ADDR_LO: st_next.station[31:0] = reg_wdata;
        `MFRC_OFF_HASH_HI: st_next.hash_tbl[63:32] = reg_wdata;
        `MFRC_OFF_HASH_LO: st_next.hash_tbl[31:0] = reg_wdata;
        `MFRC_OFF_WAKEUP: st_next.wake_en = reg_wdata[`MFRC_BIT_WAKEUP_EN];
        default: st_next.wake_en = st_reg.wake_en;
      endcase
    end

    // register reads, unmapped and reserved bits read zero
    if (reg_rd) begin
      case (reg_addr)
        `MFRC_OFF_CONTROL: begin
          st_next.rdata[`MFRC_BIT_HASH_ONLY] = st_reg.hash_only;
          st_next.rdata[`MFRC_BIT_HASH_FILT] = st_reg.hash_filt;
          st_next.rdata[`MFRC_BIT_LATE_RETRY] = st_reg.late_retry;
          st_next.rdata[`MFRC_BIT_BROADCAST_REJECT_REJ] = st_reg.broadcast_reject_rej;
          st_next.rdata[`MFRC_BIT_NO_RETRY] = st_reg.no_retry;
          st_next.rdata[`MFRC_BIT_PAD_STRIP] = st_reg.pad_strip;
          st_next.rdata[`MFRC_BACKOFF_LIMIT_HI:`MFRC_BACKOFF_LIMIT_LO] = st_reg.bo_limit;
        end
        `MFRC_OFF_ADDR_HI: st_next.rdata[15:0] = st_reg.station[47:32];
        `MFRC_OFF_ADDR_LO: st_next.rdata = st_reg.station[31:0];
        `MFRC_OFF_HASH_HI: st_next.rdata = st_reg.hash_tbl[63:32];
        `MFRC_OFF_HASH_LO: st_next.rdata = st_reg.hash_tbl[31:0];
        `MFRC_OFF_WAKEUP: st_next.rdata[`MFRC_BIT_WAKEUP_EN] = st_reg.wake_en;
        // status word: retries, attempt state, countdown and last frame flags
        `MFRC_OFF_TX_STATUS: begin
          st_next.rdata[12:8] = st_reg.retries;
          st_next.rdata[5:4] = st_reg.tx_state;
          st_next.rdata[2] = bo_busy;
          st_next.rdata[1] = st_reg.stat_late;
          st_next.rdata[0] = st_reg.stat_err;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // receive address filter and strip decision
    // broadcast is decided first, so neither filter mode can hide it
    if (rx_dest_valid) begin
      st_next.rx_valid = 1'b1;
      st_next.rx_wake = is_broadcast_reject & st_reg.wake_en & rx_wakeup_match;
      if (is_broadcast_reject) begin
        st_next.rx_accept = ~st_reg.broadcast_reject_rej | (st_reg.wake_en & rx_wakeup_match);
      end else if (is_mcast) begin
        st_next.rx_accept = st_reg.hash_filt ? hash_hit : exact_hit;
      end else if (st_reg.hash_filt & st_reg.hash_only) begin
        st_next.rx_accept = hash_hit;
      end else begin
        st_next.rx_accept = exact_hit;
      end
      // strip only short frames, otherwise pass untouched
      st_next.rx_strip = st_reg.pad_strip & (rx_len_field < `MFRC_MIN_LEN_FIELD);
    end

    // transmit attempt sequencing
    // collisions and completions are taken only while an attempt is active
    case (st_reg.tx_state)
      TX_IDLE: begin
        if (tx_start) begin
          st_next.tx_state = TX_ACTIVE;
          st_next.retries = 5'h00;
          st_next.frame_late = 1'b0;
        end
      end
      TX_ACTIVE: begin
        if (tx_done) begin
          st_next.stat_valid = 1'b1;
          st_next.stat_late = st_reg.frame_late;
          st_next.stat_err = 1'b0;
          st_next.tx_state = TX_IDLE;
        end else if (tx_collision) begin
          st_next.frame_late = late_now;
          if (tx_collision_late & ~st_reg.late_retry) begin
            st_next.tx_abandon = 1'b1;
            st_next.stat_valid = 1'b1;
            st_next.stat_late = 1'b1;
            // a single-attempt frame still owes its retry error here
            st_next.stat_err = st_reg.no_retry;
            st_next.tx_state = TX_IDLE;
          end else if (st_reg.no_retry | (tries == `MFRC_MAX_ATTEMPTS)) begin
            st_next.tx_abandon = 1'b1;
            st_next.stat_valid = 1'b1;
            st_next.stat_late = late_now;
            st_next.stat_err = 1'b1;
            st_next.tx_state = TX_IDLE;
          end else begin
            st_next.retries = tries;
            bo_load = 1'b1;
            st_next.tx_state = TX_BACKOFF;
          end
        end
      end
      TX_BACKOFF: begin
        // countdown reached zero: retry the frame
        if (bo_done) begin
          st_next.tx_retry = 1'b1;
          st_next.tx_state = TX_ACTIVE;
        end
      end
      default: st_next.tx_state = TX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, all control bits clear at reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // the struct clear covers every control bit and the backoff limit
      st_reg <= '0;
      st_reg.station <= `MFRC_STATION_RESET;
      st_reg.hash_tbl <= `MFRC_HASH_RESET;
      st_reg.tx_state <= TX_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign reg_rdata = st_reg.rdata;
  assign rx_filter_valid = st_reg.rx_valid;
  assign rx_accept = st_reg.rx_accept;
  assign rx_strip_pad_fcs = st_reg.rx_strip;
  assign rx_wakeup_hit = st_reg.rx_wake;
  assign tx_retry = st_reg.tx_retry;
  assign tx_abandon = st_reg.tx_abandon;
  assign tx_status_valid = st_reg.stat_valid;
  assign tx_status_late = st_reg.stat_late;
  assign tx_status_retry_err = st_reg.stat_err;
  // registered copy, so it trails the countdown by one cycle
  assign tx_backoff_busy = st_reg.bo_busy;

endmodule : mfrc_top
`default_nettype wire

// [tb/mfrc_top_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mfrc_defines.svh"

module mfrc_top_assertions #(
  parameter logic [15:0] SLOT_CYCLES = 16'h0200
) (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire logic [11:0] reg_addr, // address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic rx_dest_valid, // rx request
  input wire logic [47:0] rx_dest_addr, // destination
  input wire logic [15:0] rx_len_field, // length field
  input wire logic rx_wakeup_match, // wakeup match
  input wire logic rx_filter_valid, // rx answer
  input wire logic rx_accept, // accept
  input wire logic rx_strip_pad_fcs, // strip
  input wire logic rx_wakeup_hit, // wake
  input wire logic tx_collision, // collision
  input wire logic tx_collision_late, // late
  input wire logic tx_done, // sent
  input wire logic tx_retry, // retry
  input wire logic tx_abandon, // drop
  input wire logic tx_status_valid, // status
  input wire logic tx_status_late, // late flag
  input wire logic tx_status_retry_err, // retry error
  input wire logic tx_backoff_busy // backoff
);
  logic [15:0] ctl_m; // shadow of the control word
  logic wake_m; // shadow of wakeup enable
  logic [15:0] bo_cnt; // length of the current backoff
  logic bc; // broadcast destination
  assign bc = rx_dest_addr == 48'hFFFF_FFFF_FFFF;
  ////////////////////////////////////////////////////////////////////////////
  // track control writes and the backoff run length
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_m <= 16'h0000;
      wake_m <= 1'h0;
      bo_cnt <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `MFRC_OFF_CONTROL) ctl_m <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `MFRC_OFF_WAKEUP) wake_m <= reg_wdata[2];
      bo_cnt <= tx_backoff_busy ? bo_cnt + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_filt_answer: assert property (
    rx_dest_valid |=> rx_filter_valid) else $error("no filter answer");
  a_broadcast_reject_drop: assert property (
    rx_dest_valid && bc && ctl_m[11] && !(wake_m && rx_wakeup_match) |=> !rx_accept)
    else $error("broadcast not dropped");
  a_broadcast_reject_pass: assert property (
    rx_dest_valid && bc && !ctl_m[11] |=> rx_accept) else $error("broadcast dropped");
  a_wake_broadcast_reject: assert property (
    rx_dest_valid && bc && wake_m && rx_wakeup_match |=> rx_accept && rx_wakeup_hit)
    else $error("wakeup broadcast lost");
  a_strip_len: assert property (
    rx_dest_valid |=> rx_strip_pad_fcs == (ctl_m[8] && $past(rx_len_field) < 16'h002E))
    else $error("strip decision wrong");
  a_noretry_drop: assert property (
    ctl_m[10] && tx_collision && !tx_done |=> tx_abandon && tx_status_valid
    && tx_status_retry_err) else $error("single attempt not dropped");
  a_late_drop: assert property (
    !ctl_m[12] && !ctl_m[10] && tx_collision && tx_collision_late && !tx_done
    |=> tx_abandon && tx_status_late && !tx_status_retry_err) else $error("late not dropped");
  a_retry_follows: assert property (
    $fell(tx_backoff_busy) |-> ##[0:2] tx_retry) else $error("no retry after backoff");
  a_backoff_cap: assert property (
    ctl_m[7:6] == 2'h3 |-> bo_cnt <= SLOT_CYCLES + 16'h0002) else $error("backoff too long");
endmodule : mfrc_top_assertions
`default_nettype wire

// [tb/mfrc_phy_model.sv]
`timescale 1ns/1ns
`default_nettype none

module mfrc_phy_model (
  input wire logic core_clk, // clock
  input wire logic go, // start one frame
  input wire logic [4:0] n_coll, // collisions to cause
  input wire logic late_in, // collisions are late
  input wire logic tx_retry, // next attempt
  input wire logic tx_abandon, // frame dropped
  output logic tx_start, // frame begins
  output logic tx_collision, // collision seen
  output logic tx_collision_late, // collision was late
  output logic tx_done // frame sent
);
  int left; // collisions still to cause
  ////////////////////////////////////////////////////////////////////////////
  // one frame per go: collide n times, then finish unless dropped
  initial begin
    tx_start = 1'h0;
    tx_collision = 1'h0;
    tx_collision_late = 1'h0;
    tx_done = 1'h0;
    forever begin
      @(posedge core_clk);
      if (go) begin
        left = n_coll;
        tx_start <= 1'h1;
        @(posedge core_clk);
        tx_start <= 1'h0;
        forever begin
          repeat (3) @(posedge core_clk);
          if (left == 0) begin
            tx_done <= 1'h1;
            @(posedge core_clk);
            tx_done <= 1'h0;
            break;
          end
          tx_collision <= 1'h1;
          tx_collision_late <= late_in;
          @(posedge core_clk);
          tx_collision <= 1'h0;
          tx_collision_late <= 1'h0;
          left--;
          do @(posedge core_clk); while (!tx_retry && !tx_abandon);
          if (tx_abandon) break;
        end
      end
    end
  end
endmodule : mfrc_phy_model
`default_nettype wire

// [tb/tb_mfrc_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mfrc_defines.svh"

module tb_mfrc_top;
  import mfrc_pkg::*;
  logic core_clk, reset_n, reg_wr, reg_rd, rx_dest_valid, rx_wakeup_match;
  logic rx_filter_valid, rx_accept, rx_strip_pad_fcs, rx_wakeup_hit, go, late_in;
  logic tx_start, tx_collision, tx_collision_late, tx_done, tx_retry, tx_abandon;
  logic tx_status_valid, tx_status_late, tx_status_retry_err, tx_backoff_busy;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [47:0] rx_dest_addr;
  logic [15:0] rx_len_field;
  logic [4:0] n_coll;
  logic [63:0] hb; // single-bit hash table
  int error_cnt = 0;
  int n_tests = 0;
  localparam logic [47:0] STN = 48'hA1B2_C3D4_E5F6; // unicast station
  localparam logic [47:0] OTH = 48'hA1B2_C3D4_E4F6; // other unicast
  localparam logic [47:0] MC = 48'h0000_0000_0001; // multicast
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF; // broadcast
  localparam logic [11:0] CTL = `MFRC_OFF_CONTROL;

  mfrc_top #(.SLOT_CYCLES(16'h0004)) i_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rx_dest_valid, .rx_dest_addr, .rx_len_field,
    .rx_wakeup_match, .rx_filter_valid, .rx_accept, .rx_strip_pad_fcs, .rx_wakeup_hit,
    .tx_start, .tx_collision, .tx_collision_late, .tx_done, .tx_retry, .tx_abandon,
    .tx_status_valid, .tx_status_late, .tx_status_retry_err, .tx_backoff_busy);
  mfrc_phy_model i_phy (.core_clk, .go, .n_coll, .late_in, .tx_retry, .tx_abandon,
    .tx_start, .tx_collision, .tx_collision_late, .tx_done);
  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  // access tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // hash index of a destination: top six bits of a crc over bits 0 to 47
  function automatic logic [5:0] hash_idx(input logic [47:0] d);
    logic [31:0] c;
    c = `MFRC_CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      c = {c[30:0], 1'h0} ^ ((c[31] ^ d[i]) ? `MFRC_CRC_POLY : 32'h0000_0000);
    end
    return c[31:26];
  endfunction : hash_idx
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk(nm, e, reg_rdata);
  endtask : rd
  task automatic rx(input logic [47:0] d, input logic [15:0] l, input logic w,
    input logic [2:0] e);
    @(posedge core_clk);
    rx_dest_valid <= 1'h1;
    rx_dest_addr <= d;
    rx_len_field <= l;
    rx_wakeup_match <= w;
    @(posedge core_clk);
    rx_dest_valid <= 1'h0;
    #1 chk("rx_valid", 32'h1, {31'h0, rx_filter_valid});
    chk("rx_flags", {29'h0, e}, {29'h0, rx_accept, rx_strip_pad_fcs, rx_wakeup_hit});
  endtask : rx
  task automatic tx(input logic [4:0] n, input logic l, input logic [4:0] er,
    input logic [1:0] es, input int bmin, input int bmax);
    int k;
    int b;
    logic [4:0] r;
    @(posedge core_clk);
    go <= 1'h1;
    n_coll <= n;
    late_in <= l;
    @(posedge core_clk);
    go <= 1'h0;
    r = 5'h00;
    b = 0;
    for (k = 0; k < 3000 && tx_status_valid !== 1'h1; k++) begin
      @(posedge core_clk);
      #1 if (tx_retry === 1'h1) r++;
      if (tx_backoff_busy === 1'h1) b++;
    end
    chk("tx_status_valid", 32'h1, {31'h0, tx_status_valid});
    chk("tx_retries", {27'h0, er}, {27'h0, r});
    chk("tx_status", {30'h0, es}, {30'h0, tx_status_late, tx_status_retry_err});
    // countdown cycles over the frame: 4r+1 per backoff, r drawn below the cap
    n_tests++;
    if (b < bmin || b > bmax) begin
      error_cnt++;
      $display("ERROR tx_backoff_cycles expected %0d to %0d seen %0d", bmin, bmax, b);
    end
  endtask : tx
  task automatic complete_run();
    $display("TB: %0d errors in %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_n = 1'h0;
    {reg_wr, reg_rd, rx_dest_valid, rx_wakeup_match, go, late_in} = 6'h00;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    rx_dest_addr = 48'h0;
    rx_len_field = 16'h0;
    n_coll = 5'h00;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'h1;
    rd(CTL, 32'h0, "ctl_reset");
    wr(CTL, 32'hFFFF_FFFF);
    rd(CTL, 32'h0000_BDC0, "ctl_fields");
    rd(12'h1F0, 32'h0, "unmapped");
    wr(CTL, 32'h0);
    wr(`MFRC_OFF_ADDR_HI, {16'h0, STN[47:32]});
    wr(`MFRC_OFF_ADDR_LO, STN[31:0]);
    wr(`MFRC_OFF_HASH_HI, 32'hFFFF_FFFF);
    wr(`MFRC_OFF_HASH_LO, 32'hFFFF_FFFF);
    rx(STN, 16'h0040, 1'h0, 3'h4);
    rx(OTH, 16'h0040, 1'h0, 3'h0);
    rx(MC, 16'h0040, 1'h0, 3'h0);
    wr(CTL, 32'h0000_2000);
    rx(MC, 16'h0040, 1'h0, 3'h4);
    rx(OTH, 16'h0040, 1'h0, 3'h0);
    rx(STN, 16'h0040, 1'h0, 3'h4);
    wr(CTL, 32'h0000_A000);
    rx(OTH, 16'h0040, 1'h0, 3'h4);
    wr(`MFRC_OFF_HASH_HI, 32'h0);
    wr(`MFRC_OFF_HASH_LO, 32'h0);
    rx(MC, 16'h0040, 1'h0, 3'h0);
    hb = 64'h1 << hash_idx(MC);
    wr(`MFRC_OFF_HASH_HI, hb[63:32]);
    wr(`MFRC_OFF_HASH_LO, hb[31:0]);
    rx(MC, 16'h0040, 1'h0, 3'h4);
    wr(`MFRC_OFF_HASH_HI, ~hb[63:32]);
    wr(`MFRC_OFF_HASH_LO, ~hb[31:0]);
    rx(MC, 16'h0040, 1'h0, 3'h0);
    wr(CTL, 32'h0);
    rx(BC, 16'h0040, 1'h0, 3'h4);
    wr(CTL, 32'h0000_0800);
    rx(BC, 16'h0040, 1'h0, 3'h0);
    wr(`MFRC_OFF_WAKEUP, 32'h0000_0004);
    rx(BC, 16'h0040, 1'h1, 3'h5);
    rx(BC, 16'h0040, 1'h0, 3'h0);
    wr(CTL, 32'h0000_0100);
    rx(STN, 16'h002D, 1'h0, 3'h6);
    rx(STN, 16'h002E, 1'h0, 3'h4);
    wr(CTL, 32'h0);
    rx(STN, 16'h002D, 1'h0, 3'h4);
    wr(CTL, 32'h0000_0400);
    tx(5'h01, 1'h0, 5'h00, 2'h1, 0, 0);
    tx(5'h01, 1'h1, 5'h00, 2'h3, 0, 0);
    wr(CTL, 32'h0);
    tx(5'h01, 1'h1, 5'h00, 2'h2, 0, 0);
    wr(CTL, 32'h0000_1000);
    tx(5'h02, 1'h1, 5'h02, 2'h2, 2, 18);
    wr(CTL, 32'h0000_00C0);
    tx(5'h10, 1'h0, 5'h0F, 2'h1, 16, 75);
    tx(5'h0F, 1'h0, 5'h0F, 2'h0, 15, 75);
    wr(CTL, 32'h0000_0080);
    tx(5'h03, 1'h0, 5'h03, 2'h0, 3, 47);
    rd(12'h200, 32'h0000_0300, "tx_stat");
    complete_run();
  end
endmodule : tb_mfrc_top

bind mfrc_top mfrc_top_assertions #(.SLOT_CYCLES(SLOT_CYCLES)) i_chk (.core_clk, .reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .rx_dest_valid, .rx_dest_addr, .rx_len_field,
  .rx_wakeup_match, .rx_filter_valid, .rx_accept, .rx_strip_pad_fcs, .rx_wakeup_hit,
  .tx_collision, .tx_collision_late, .tx_done, .tx_retry, .tx_abandon, .tx_status_valid,
  .tx_status_late, .tx_status_retry_err, .tx_backoff_busy);
`default_nettype wire
